// *** hw/hic_defs.svh ***
// Offsets, field positions, reset values and timing constants of the mode block
`ifndef HIC_DEFS_SVH
`define HIC_DEFS_SVH
`define CLK_MHZ            200
`define CLK_PERIOD_NS      5
`define REF_CLK_MHZ        50
`define REF_HALF_CYC       (`CLK_MHZ / `REF_CLK_MHZ / 2)
`define REG_SOFT_RESET     8'h00
`define REG_MODE_CFG       8'h01
`define REG_SPEED          8'h0a
`define REG_PHY_ADDR       8'h1e
`define REG_STATUS         8'h1f
`define SOFT_RESET_BIT     0
`define CFG_OVERRIDE_BIT   0
`define CFG_MODE_LO        3
`define CFG_MODE_HI        4
`define CFG_MII_BIT        5
`define CFG_EXT_CLK_BIT    6
`define PHY_ADDR_LO        4
`define PHY_ADDR_HI        6
`define CFG_RESET          8'h40
`define SPEED_RESET        8'h13
`define PHY_ADDR_RESET     8'h00
`define I2C_ADDR_BASE      5'h07
`define STRAP_SETTLE_CYC   4
`define MDC_HALF_NS        200
`define MDC_HALF_CYC       ((`MDC_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_INTERVAL_NS   1000000
`define POLL_INTERVAL_CYC  (`POLL_INTERVAL_NS / `CLK_PERIOD_NS)
`define MDIO_BMSR          5'h01
`define MDIO_LINK_BIT      2
`define MDIO_FRAME_BITS    64
`define MDIO_DRIVE_BITS    46
`define MDIO_DATA_LAST     63
`endif

// *** hw/hic_pkg.sv ***
// Types shared by the mode block and its management poller
package hic_pkg;
  typedef enum logic [1:0] {
    MODE_PHY  = 2'b00,
    MODE_SOC  = 2'b01,
    MODE_PASS = 2'b10
  } host_mode_t;

  typedef enum logic [2:0] {
    I2_IDLE  = 3'b000,
    I2_ADDR  = 3'b001,
    I2_ACK   = 3'b010,
    I2_PTR   = 3'b011,
    I2_WDATA = 3'b100,
    I2_RDATA = 3'b101,
    I2_RACK  = 3'b110
  } i2c_state_t;

  typedef enum logic {
    MD_WAIT  = 1'b0,
    MD_FRAME = 1'b1
  } mdio_state_t;
endpackage : hic_pkg

// *** hw/mdio_link_poll.sv ***
// Periodic management read of the external PHY's basic status register
`timescale 1ns/1ps
`include "hic_defs.svh"

module mdio_link_poll #(
  parameter int POLL_CYC = `POLL_INTERVAL_CYC,
  parameter int HALF_CYC = `MDC_HALF_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control
  input  wire logic       poll_en,
  input  wire logic [4:0] phy_addr,
  // Management pins
  output logic            mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  // Result
  output logic            link_up
);
  localparam int WW = $clog2(POLL_CYC + 1);
  localparam int HW = $clog2(HALF_CYC + 1);
  localparam logic [5:0] LINK_IDX = 6'(`MDIO_DATA_LAST - `MDIO_LINK_BIT);
  localparam logic [5:0] LAST_IDX = 6'(`MDIO_FRAME_BITS - 1);
  localparam logic [5:0] DRV_LAST = 6'(`MDIO_DRIVE_BITS - 1);

  hic_pkg::mdio_state_t st_r;
  logic [WW-1:0]        wait_cnt_r;
  logic [HW-1:0]        half_cnt_r;
  logic [5:0]           bit_idx_r;
  logic [63:0]          frame_r;
  logic                 mdio_s1_r;
  logic                 mdio_s2_r;

  // Preamble, start, read op, address, register, turnaround, data
  wire [63:0] frame_init = {32'hffff_ffff, 2'b01, 2'b10, phy_addr, `MDIO_BMSR,
                            2'b11, 16'hffff};
  wire        wait_done  = (wait_cnt_r == WW'(POLL_CYC - 1));
  wire        half_done  = (half_cnt_r == HW'(HALF_CYC - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdio_s1_r <= 1'b0;
      mdio_s2_r <= 1'b0;
    end else begin
      mdio_s1_r <= mdio_i;
      mdio_s2_r <= mdio_s1_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r       <= hic_pkg::MD_WAIT;
      wait_cnt_r <= '0;
      half_cnt_r <= '0;
      bit_idx_r  <= 6'h00;
      frame_r    <= 64'h0;
      mdc        <= 1'b0;
      mdio_o     <= 1'b1;
      mdio_oe    <= 1'b0;
      link_up    <= 1'b0;
    end else begin
      unique case (st_r)
        hic_pkg::MD_WAIT: begin
          mdc     <= 1'b0;
          mdio_oe <= 1'b0;
          if (!poll_en) begin
            wait_cnt_r <= '0;
            link_up    <= 1'b0;
          end else if (wait_done) begin
            // Clause 22 read frame to the status register
            wait_cnt_r <= '0;
            st_r       <= hic_pkg::MD_FRAME;
            frame_r    <= frame_init;
            bit_idx_r  <= 6'h00;
            half_cnt_r <= '0;
            mdio_o     <= frame_init[63];
            mdio_oe    <= 1'b1;
          end else begin
            wait_cnt_r <= wait_cnt_r + WW'(1);
          end
        end
        hic_pkg::MD_FRAME: begin
          if (!poll_en) begin
            // Mode left PHY-facing: cut the frame so the pins go quiet
            st_r       <= hic_pkg::MD_WAIT;
            half_cnt_r <= '0;
            mdc        <= 1'b0;
            mdio_o     <= 1'b1;
            mdio_oe    <= 1'b0;
            link_up    <= 1'b0;
          end else if (!half_done) begin
            half_cnt_r <= half_cnt_r + HW'(1);
          end else begin
            half_cnt_r <= '0;
            mdc        <= ~mdc;
            // Sample on the rising edge; the PHY drives after the falling one
            if (!mdc && bit_idx_r == LINK_IDX) begin
              link_up <= mdio_s2_r;
            end
            if (mdc) begin
              if (bit_idx_r == LAST_IDX) begin
                st_r    <= hic_pkg::MD_WAIT;
                mdio_oe <= 1'b0;
              end else begin
                bit_idx_r <= bit_idx_r + 6'h01;
                frame_r   <= {frame_r[62:0], 1'b1};
                mdio_o    <= frame_r[62];
                mdio_oe   <= (bit_idx_r < DRV_LAST);
              end
            end
          end
        end
      endcase
    end
  end
endmodule : mdio_link_poll

// *** hw/host_interface_mode_config.sv ***
// Host-side interface mode selection, register bank and PHY status polling
`timescale 1ns/1ps
`include "hic_defs.svh"

// Function
// - MII port has no carrier or collision
// - Low LED strap or override+bit5=0 selects RMII
// - Bit6 one takes external reference clock
// - Bit6 zero drives generated 50 MHz clock
// - PHY mode polls PHY link status periodically
// - PHY address is reg bits6:4 plus straps
// - No reset output toward the external PHY
// - High LED strap or override+bit5=1 selects MII
// - Select strap high or override+01 selects SOC
// - SOC mode never uses the management pins
// - Register values override the latched straps
// - New mode applies only after soft reset
// - 0x61/0x69/0x71 decode as MII modes
// - 0x01/0x09/0x11 decode as internal-clock RMII
// - 0x41/0x49/0x51 decode as external-clock RMII
// - Straps are latched after hardware reset
// - Mode bits 10 select pass-through
// - Override clear follows straps, set follows register
module host_interface_mode_config #(
  parameter int POLL_CYC = `POLL_INTERVAL_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Strap pins; the LED strap doubles as the link indicator
  input  wire logic       link_led_and_mii_strap_i,
  output logic            link_led_and_mii_strap_o,
  output logic            link_led_and_mii_strap_oe,
  input  wire logic       host_side_select_strap,
  input  wire logic       addr_strap_low,
  input  wire logic       addr_strap_high,
  // Register access pins
  input  wire logic       scl,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Coax link state from the modem core
  input  wire logic       coax_link_up,
  // Reference clock pin
  output logic            ref_clock_output_pin,
  output logic            ref_clock_output_oe,
  // PHY management pins
  output logic            mdc,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe,
  // Active mode toward the datapath
  output logic            mii_select,
  output logic            rmii_select,
  output hic_pkg::host_mode_t host_mode,
  output logic            ref_clock_external,
  output logic [7:0]      speed_code,
  output logic            speed_manual,
  output logic            phy_link_up,
  output logic            soft_reset_pulse
);
  // Synchronised pins: 0 scl, 1 sda, 2 led strap, 3 select strap, 4 a0, 5 a1
  logic [5:0]          pin_s1_r;
  logic [5:0]          pin_s2_r;
  logic                scl_d_r;
  logic                sda_d_r;
  logic [2:0]          settle_cnt_r;
  logic                straps_done_r;
  logic                strap_mii_r;
  logic                strap_soc_r;
  logic [7:0]          cfg_r;
  logic [7:0]          speed_r;
  logic [7:0]          phy_addr_r;
  hic_pkg::i2c_state_t st_r;
  hic_pkg::i2c_state_t after_r;
  logic [3:0]          bit_cnt_r;
  logic [7:0]          shift_r;
  logic [7:0]          tx_r;
  logic [7:0]          ptr_r;
  logic                nack_r;
  logic                wr_stb_r;
  logic [7:0]          wr_addr_r;
  logic [7:0]          wr_data_r;
  logic                ref_cnt_r;
  logic                phy_poll_link;

  // Mode picked from straps or register, shared by both apply points
  function automatic logic [3:0] pick_mode(input logic [7:0] cfg,
                                           input logic strap_mii,
                                           input logic strap_soc);
    logic       mii;
    logic [1:0] md;
    mii = strap_mii;
    md  = strap_soc ? hic_pkg::MODE_SOC : hic_pkg::MODE_PHY;
    if (cfg[`CFG_OVERRIDE_BIT]) begin
      mii = cfg[`CFG_MII_BIT];
      // Reserved code 11 falls back to PHY-facing
      md  = (cfg[`CFG_MODE_HI:`CFG_MODE_LO] == 2'b11) ? hic_pkg::MODE_PHY
                                                      : cfg[`CFG_MODE_HI:`CFG_MODE_LO];
    end
    return {mii, md, cfg[`CFG_EXT_CLK_BIT]};
  endfunction : pick_mode

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] cfg,
                                          input logic [7:0] spd, input logic [7:0] pa,
                                          input logic [7:0] stat);
    unique case (a)
      `REG_MODE_CFG: return cfg;
      `REG_SPEED:    return spd;
      `REG_PHY_ADDR: return pa;
      `REG_STATUS:   return stat;
      default:       return 8'h00;
    endcase
  endfunction : reg_read

  wire scl_s     = pin_s2_r[0];
  wire sda_s     = pin_s2_r[1];
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire [6:0] dev_addr = {`I2C_ADDR_BASE, pin_s2_r[5], pin_s2_r[4]};
  wire [7:0] status_word = {2'b00, straps_done_r, phy_link_up, ref_clock_external,
                            host_mode, mii_select};
  wire [7:0] rd_word = reg_read(ptr_r, cfg_r, speed_r, phy_addr_r, status_word);
  wire [4:0] phy_addr = {phy_addr_r[`PHY_ADDR_HI:`PHY_ADDR_LO],
                         pin_s2_r[5], pin_s2_r[4]};
  wire [3:0] strap_pick = pick_mode(`CFG_RESET, pin_s2_r[2], pin_s2_r[3]);
  wire [3:0] soft_pick  = pick_mode(cfg_r, strap_mii_r, strap_soc_r);
  wire       settle_end = (settle_cnt_r == 3'(`STRAP_SETTLE_CYC - 1));
  wire       soft_hit   = wr_stb_r && (wr_addr_r == `REG_SOFT_RESET)
                          && wr_data_r[`SOFT_RESET_BIT];
  wire       poll_en    = straps_done_r && (host_mode == hic_pkg::MODE_PHY);

  assign rmii_select   = ~mii_select;
  assign sda_o         = 1'b0;
  assign speed_manual  = cfg_r[`CFG_OVERRIDE_BIT];
  assign phy_link_up   = phy_poll_link;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      pin_s1_r <= {addr_strap_high, addr_strap_low, host_side_select_strap,
                   link_led_and_mii_strap_i, sda_i, scl};
      pin_s2_r <= pin_s1_r;
      scl_d_r  <= pin_s2_r[0];
      sda_d_r  <= pin_s2_r[1];
    end
  end

  // Strap capture after release, then the soft-reset apply point
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt_r       <= 3'h0;
      straps_done_r      <= 1'b0;
      strap_mii_r        <= 1'b1;
      strap_soc_r        <= 1'b0;
      mii_select         <= 1'b1;
      host_mode          <= hic_pkg::MODE_PHY;
      ref_clock_external <= 1'b1;
      speed_code         <= `SPEED_RESET;
      soft_reset_pulse   <= 1'b0;
    end else begin
      soft_reset_pulse <= soft_hit;
      if (!straps_done_r) begin
        settle_cnt_r <= settle_cnt_r + 3'h1;
        if (settle_end) begin
          straps_done_r      <= 1'b1;
          strap_mii_r        <= pin_s2_r[2];
          strap_soc_r        <= pin_s2_r[3];
          mii_select         <= strap_pick[3];
          host_mode          <= hic_pkg::host_mode_t'(strap_pick[2:1]);
          ref_clock_external <= strap_pick[0];
        end
      end else if (soft_reset_pulse) begin
        mii_select         <= soft_pick[3];
        host_mode          <= hic_pkg::host_mode_t'(soft_pick[2:1]);
        ref_clock_external <= soft_pick[0];
        speed_code         <= cfg_r[`CFG_OVERRIDE_BIT] ? speed_r : speed_code;
      end
    end
  end

  // Register bank; soft reset bit reads back zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r      <= `CFG_RESET;
      speed_r    <= `SPEED_RESET;
      phy_addr_r <= `PHY_ADDR_RESET;
    end else if (wr_stb_r) begin
      if (wr_addr_r == `REG_MODE_CFG) begin
        cfg_r <= wr_data_r;
      end
      if (wr_addr_r == `REG_SPEED) begin
        speed_r <= wr_data_r;
      end
      if (wr_addr_r == `REG_PHY_ADDR) begin
        phy_addr_r <= wr_data_r;
      end
    end
  end

  // Two-wire register slave with auto-incrementing pointer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r      <= hic_pkg::I2_IDLE;
      after_r   <= hic_pkg::I2_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      nack_r    <= 1'b0;
      sda_oe    <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_det) begin
        st_r      <= hic_pkg::I2_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (stop_det) begin
        st_r   <= hic_pkg::I2_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == hic_pkg::I2_RACK) begin
          nack_r <= sda_s;
        end else if (st_r != hic_pkg::I2_IDLE && st_r != hic_pkg::I2_ACK) begin
          shift_r   <= {shift_r[6:0], sda_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end else if (scl_fall) begin
        unique case (st_r)
          hic_pkg::I2_IDLE: begin
            sda_oe <= 1'b0;
          end
          hic_pkg::I2_ADDR: begin
            if (bit_cnt_r == 4'h8) begin
              if (shift_r[7:1] == dev_addr) begin
                sda_oe  <= 1'b1;
                st_r    <= hic_pkg::I2_ACK;
                after_r <= shift_r[0] ? hic_pkg::I2_RDATA : hic_pkg::I2_PTR;
              end else begin
                st_r <= hic_pkg::I2_IDLE;
              end
            end
          end
          hic_pkg::I2_PTR, hic_pkg::I2_WDATA: begin
            if (bit_cnt_r == 4'h8) begin
              sda_oe  <= 1'b1;
              st_r    <= hic_pkg::I2_ACK;
              after_r <= hic_pkg::I2_WDATA;
              if (st_r == hic_pkg::I2_PTR) begin
                ptr_r <= shift_r;
              end else begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= shift_r;
                ptr_r     <= ptr_r + 8'h01;
              end
            end
          end
          hic_pkg::I2_ACK, hic_pkg::I2_RACK: begin
            bit_cnt_r <= 4'h0;
            if (st_r == hic_pkg::I2_RACK && nack_r) begin
              st_r   <= hic_pkg::I2_IDLE;
              sda_oe <= 1'b0;
            end else if (st_r == hic_pkg::I2_RACK || after_r == hic_pkg::I2_RDATA) begin
              st_r   <= hic_pkg::I2_RDATA;
              tx_r   <= rd_word;
              sda_oe <= ~rd_word[7];
              ptr_r  <= ptr_r + 8'h01;
            end else begin
              st_r   <= after_r;
              sda_oe <= 1'b0;
            end
          end
          hic_pkg::I2_RDATA: begin
            if (bit_cnt_r == 4'h8) begin
              st_r   <= hic_pkg::I2_RACK;
              sda_oe <= 1'b0;
            end else begin
              tx_r   <= {tx_r[6:0], 1'b0};
              sda_oe <= ~tx_r[6];
            end
          end
          default: begin
            st_r   <= hic_pkg::I2_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // LED pin stays released until the strap is taken, then shows link low-true
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_led_and_mii_strap_o  <= 1'b1;
      link_led_and_mii_strap_oe <= 1'b0;
    end else begin
      link_led_and_mii_strap_o  <= ~coax_link_up;
      link_led_and_mii_strap_oe <= straps_done_r;
    end
  end

  // 50 MHz reference from the 200 MHz clock; pin released when external
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_cnt_r            <= 1'b0;
      ref_clock_output_pin <= 1'b0;
      ref_clock_output_oe  <= 1'b0;
    end else begin
      ref_clock_output_oe <= ~ref_clock_external;
      if (ref_clock_external) begin
        ref_cnt_r            <= 1'b0;
        ref_clock_output_pin <= 1'b0;
      end else if (ref_cnt_r == 1'(`REF_HALF_CYC - 1)) begin
        ref_cnt_r            <= 1'b0;
        ref_clock_output_pin <= ~ref_clock_output_pin;
      end else begin
        ref_cnt_r <= ref_cnt_r + 1'b1;
      end
    end
  end

  // Only data, enable, error and clock lines reach the MII datapath
  // No reset pin is driven toward the external PHY
  mdio_link_poll #(
    .POLL_CYC (POLL_CYC),
    .HALF_CYC (`MDC_HALF_CYC)
  ) u_poll (
    .clk      (clk),
    .reset_n  (reset_n),
    .poll_en  (poll_en),
    .phy_addr (phy_addr),
    .mdc      (mdc),
    .mdio_i   (mdio_i),
    .mdio_o   (mdio_o),
    .mdio_oe  (mdio_oe),
    .link_up  (phy_poll_link)
  );
endmodule : host_interface_mode_config

// *** sim/host_interface_mode_config_properties.sv ***
// Port-level properties of the host interface mode block
`timescale 1ns/1ps
module host_interface_mode_config_properties (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset_n,
  // Observed outputs
  input wire logic                mii_select,
  input wire logic                rmii_select,
  input wire hic_pkg::host_mode_t host_mode,
  input wire logic                ref_clock_external,
  input wire logic                ref_clock_output_pin,
  input wire logic                ref_clock_output_oe,
  input wire logic                mdc,
  input wire logic                mdio_oe,
  input wire logic                phy_link_up,
  input wire logic                soft_reset_pulse,
  input wire logic                link_led_and_mii_strap_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  rmii_mii_a: assert property (rmii_select == !mii_select)
    else $error("rmii and mii selects disagree");
  pulse_width_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");
  // Mode only moves at strap capture or just after a soft reset
  // LED drive starts one cycle after strap capture, so it marks the capture as done
  mode_hold_a: assert property (link_led_and_mii_strap_oe && !$past(soft_reset_pulse)
    |-> $stable(mii_select) && $stable(host_mode) && $stable(ref_clock_external))
    else $error("mode changed without reset");
  // A few cycles of lag allowed for a frame being cut off
  soc_no_mgmt_a: assert property ((host_mode != hic_pkg::MODE_PHY)[*4]
    |-> !mdc && !mdio_oe)
    else $error("management pins active outside PHY mode");
  soc_link_low_a: assert property ((host_mode != hic_pkg::MODE_PHY)[*4]
    |-> !phy_link_up)
    else $error("link flag set outside PHY mode");
  mdc_high_a: assert property ($rose(mdc)
    |=> (mdc || host_mode != hic_pkg::MODE_PHY)[*8])
    else $error("management clock high phase too short");
  // Pin and enable drop together when the clock source flips to external
  ref_toggle_a: assert property ($rose(ref_clock_output_pin)
    |=> (ref_clock_output_pin || !ref_clock_output_oe)
    ##1 (!ref_clock_output_pin || !ref_clock_output_oe))
    else $error("reference clock not two cycles per phase");
  // Enable is registered from the selected source, one cycle behind it
  ext_clk_quiet_a: assert property (ref_clock_output_oe == !$past(ref_clock_external)
    && (ref_clock_output_oe || !ref_clock_output_pin))
    else $error("reference clock pin driven with external clock");

  cover property (soft_reset_pulse);
  cover property ($rose(phy_link_up));
  cover property (host_mode == hic_pkg::MODE_PASS);
endmodule : host_interface_mode_config_properties

bind host_interface_mode_config host_interface_mode_config_properties chk_inst (
  .clk(clk), .reset_n(reset_n), .mii_select(mii_select), .rmii_select(rmii_select),
  .host_mode(host_mode), .ref_clock_external(ref_clock_external),
  .ref_clock_output_pin(ref_clock_output_pin), .ref_clock_output_oe(ref_clock_output_oe),
  .mdc(mdc), .mdio_oe(mdio_oe), .phy_link_up(phy_link_up),
  .soft_reset_pulse(soft_reset_pulse), .link_led_and_mii_strap_oe(link_led_and_mii_strap_oe));

// *** sim/phy_mdio_model.sv ***
// Behavioural external PHY answering management reads of its status register
`timescale 1ns/1ps
module phy_mdio_model #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  // Management pins
  input  wire logic mdc,
  input  wire logic mdio_oe,
  input  wire logic mdio,
  // Link state to report
  input  wire logic link,
  // Drive toward the shared line
  output logic      drv,
  output logic      val
);
  logic [9:0]  sr;
  logic [15:0] word;
  int          idx;
  wire         hit = (sr == {PHY_ADDR, 5'h01});
  assign word = {8'h78, 5'h01, link, 2'b01};
  initial begin
    sr = '0;
    idx = 19;
    drv = 1'b0;
    val = 1'b1;
  end
  // Count falls after release: turnaround, then sixteen data bits
  always @(posedge mdc or negedge mdc) begin
    if (mdc) begin
      if (mdio_oe) begin
        sr = {sr[8:0], mdio};
        idx = 0;
      end
    end else begin
      if (idx < 19) idx = idx + 1;
      drv = hit && idx >= 2 && idx <= 18;
      val = (idx == 2) ? 1'b0 : word[(18 - idx) & 15];
    end
  end
endmodule : phy_mdio_model

// *** sim/testbench.sv ***
// Self-checking bench for the host interface mode block
`timescale 1ns/1ps
module testbench;
  localparam int         H = 16;
  localparam logic [6:0] DEV = 7'h1e;
  logic clk, reset_n, scl_m, sda_m, led_strap, sel_strap, link, mdc;
  logic led_o, led_oe, sda_o, sda_oe, mdio_o, mdio_oe, phy_drv, phy_val;
  logic mii_select, phy_link_up, ref_clock_external, ref_oe, speed_manual;
  logic [7:0] speed_code;
  hic_pkg::host_mode_t host_mode;
  int failures, n_checks;
  // Open-drain and pulled-up lines resolved here
  wire sda_line  = (sda_oe ? sda_o : 1'b1) & sda_m;
  wire mdio_line = mdio_oe ? mdio_o : (phy_drv ? phy_val : 1'b1);
  wire led_line  = led_oe ? led_o : led_strap;

  host_interface_mode_config #(.POLL_CYC(300)) host_interface_mode_config_inst (
    .clk(clk), .reset_n(reset_n), .link_led_and_mii_strap_i(led_line),
    .link_led_and_mii_strap_o(led_o), .link_led_and_mii_strap_oe(led_oe),
    .host_side_select_strap(sel_strap), .addr_strap_low(1'b0), .addr_strap_high(1'b1),
    .scl(scl_m), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .coax_link_up(1'b0),
    .ref_clock_output_pin(), .ref_clock_output_oe(ref_oe), .mdc(mdc), .mdio_i(mdio_line),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mii_select(mii_select), .rmii_select(),
    .host_mode(host_mode), .ref_clock_external(ref_clock_external),
    .speed_code(speed_code), .speed_manual(speed_manual), .phy_link_up(phy_link_up),
    .soft_reset_pulse());

  phy_mdio_model #(.PHY_ADDR({3'b011, 1'b1, 1'b0})) phy_mdio_model_inst (
    .mdc(mdc), .mdio_oe(mdio_oe), .mdio(mdio_line), .link(link),
    .drv(phy_drv), .val(phy_val));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Pause after each fall so the synced scl never sees sda move with it
  task automatic i2c_bit(input logic b, output logic r);
    sda_m = b;
    idle(H);
    scl_m = 1'b1;
    idle(H);
    r = sda_line;
    scl_m = 1'b0;
    idle(4);
  endtask : i2c_bit

  task automatic i2c_start();
    sda_m = 1'b1;
    idle(H);
    scl_m = 1'b1;
    idle(H);
    sda_m = 1'b0;
    idle(H);
    scl_m = 1'b0;
    idle(4);
  endtask : i2c_start

  task automatic i2c_stop();
    sda_m = 1'b0;
    idle(H);
    scl_m = 1'b1;
    idle(H);
    sda_m = 1'b1;
    idle(H);
  endtask : i2c_stop

  task automatic i2c_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(d[i], r);
      q[i] = r;
    end
    i2c_bit(1'b1, r);
    ack = !r;
  endtask : i2c_byte

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    logic       k0, k1, k2;
    i2c_start();
    i2c_byte({DEV, 1'b0}, q, k0);
    i2c_byte(a, q, k1);
    i2c_byte(v, q, k2);
    i2c_stop();
    chk("write acks", 8'h01, {7'h0, k0 & k1 & k2});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] q;
    logic       k0, k1, k2, k3;
    i2c_start();
    i2c_byte({DEV, 1'b0}, q, k0);
    i2c_byte(a, q, k1);
    i2c_start();
    i2c_byte({DEV, 1'b1}, q, k2);
    i2c_byte(8'hff, v, k3);
    i2c_stop();
    chk("read acks", 8'h01, {7'h0, k0 & k1 & k2});
  endtask : rd

  task automatic expect_mode(input logic m, input logic [1:0] hm, input logic ext);
    chk("mii", {7'h0, m}, {7'h0, mii_select});
    chk("mode", {6'h0, hm}, {6'h0, host_mode});
    chk("ext clock", {7'h0, ext}, {7'h0, ref_clock_external});
    chk("ref oe", {7'h0, !ext}, {7'h0, ref_oe});
  endtask : expect_mode

  task automatic t_straps(input logic led, input logic sel);
    led_strap = led;
    sel_strap = sel;
    reset_n = 1'b0;
    idle(16);
    reset_n = 1'b1;
    idle(12);
    expect_mode(led, {1'b0, sel}, 1'b1);
    chk("led pin", 8'h03, {6'h0, led_oe, led_o});
  endtask : t_straps

  task automatic t_regs();
    logic [7:0] v;
    rd(8'h01, v);
    chk("config reset", 8'h40, v);
    rd(8'h0a, v);
    chk("speed reset", 8'h13, v);
    rd(8'h05, v);
    chk("unmapped", 8'h00, v);
  endtask : t_regs

  task automatic t_poll();
    logic [7:0] v;
    link = 1'b1;
    wr(8'h1e, 8'h30);
    rd(8'h1e, v);
    chk("phy addr reg", 8'h30, v);
    // Low first: an absent PHY reads high through the pull-up
    for (int s = 0; s <= 1; s++) begin
      link = s[0];
      for (int i = 0; i < 20000 && phy_link_up !== s[0]; i++) idle(1);
      chk("link", {7'h0, s[0]}, {7'h0, phy_link_up});
      if (phy_link_up !== s[0]) wrap_up();
    end
  endtask : t_poll

  task automatic t_modes();
    logic [7:0] cfg [9] = '{8'h61, 8'h69, 8'h71, 8'h01, 8'h09, 8'h11, 8'h41, 8'h49, 8'h51};
    logic [7:0] p;
    p = 8'h40;
    foreach (cfg[i]) begin
      wr(8'h01, cfg[i]);
      expect_mode(p[5], p[4:3], p[6]);
      wr(8'h0a, 8'h0c);
      wr(8'h00, 8'h01);
      idle(4);
      expect_mode(cfg[i][5], cfg[i][4:3], cfg[i][6]);
      chk("speed", 8'h0c, speed_code);
      chk("manual", 8'h01, {7'h0, speed_manual});
      p = cfg[i];
    end
  endtask : t_modes

  task automatic t_override_off();
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h01);
    idle(4);
    expect_mode(1'b0, 2'b00, 1'b0);
  endtask : t_override_off

  initial begin
    failures = 0;
    n_checks = 0;
    reset_n = 1'b0;
    scl_m = 1'b1;
    sda_m = 1'b1;
    led_strap = 1'b0;
    sel_strap = 1'b0;
    link = 1'b0;
    t_straps(1'b0, 1'b0);
    t_regs();
    t_poll();
    t_modes();
    t_override_off();
    t_straps(1'b1, 1'b1);
    wrap_up();
  end
endmodule : testbench
